// ---- verilog/fipc_consts.svh ----
`ifndef FIPC_CONSTS_SVH
`define FIPC_CONSTS_SVH

// register offsets
`define FIPC_ADDR_PIN_CFG 8'h23
`define FIPC_ADDR_IND_CFG 8'h24
`define FIPC_ADDR_MASK 8'h25
`define FIPC_ADDR_DETECT_FIRST 8'h26
`define FIPC_ADDR_DETECT_SECOND 8'h27
`define FIPC_ADDR_EVT_STATUS 8'h40
`define FIPC_ADDR_EVT_CLEAR 8'h41
`define FIPC_ADDR_EVT_ENABLE 8'h42

// reset values
`define FIPC_PIN_CFG_RST 8'h21
`define FIPC_IND_CFG_RST 8'h00
`define FIPC_MASK_RST 8'h00
`define FIPC_EVT_RST 3'h0

// pin configuration fields
`define FIPC_DRIVE_HI 7
`define FIPC_DRIVE_LO 5
`define FIPC_GPO_BIT 4
`define FIPC_MODE_HI 2
`define FIPC_MODE_LO 0

// indication configuration field
`define FIPC_STYLE_HI 7
`define FIPC_STYLE_LO 6

// pin function codes
`define FIPC_MODE_OFF 3'h0
`define FIPC_MODE_INT 3'h1
`define FIPC_MODE_GPO 3'h3
`define FIPC_MODE_CLK 3'h4

// drive style codes
`define FIPC_DRV_PUSH_PULL 3'h0
`define FIPC_DRV_OD_LOW 3'h1
`define FIPC_DRV_OD_HIGH 3'h2
`define FIPC_DRV_OD_LOW_PU 3'h3
`define FIPC_DRV_OD_HIGH_PD 3'h4

// indication style codes
`define FIPC_STYLE_SINGLE 2'h0
`define FIPC_STYLE_REPEAT 2'h1
`define FIPC_STYLE_HOLD 2'h2

// mask layout
`define FIPC_M_OVERCURRENT 7
`define FIPC_M_ANALOG_UV 6
`define FIPC_M_CLK_ERR_B 5
`define FIPC_M_OVERTEMP 4
`define FIPC_M_BROWNOUT 3
`define FIPC_M_CLK_ERR_A 2
`define FIPC_M_MOD_HALT 1
`define FIPC_M_WORD_HALT 0

// first sticky detection layout
`define FIPC_D1_OVERCURRENT 7
`define FIPC_D1_ANALOG_UV 6
`define FIPC_D1_CLK_ERR_A 5
`define FIPC_D1_OVERTEMP 4
`define FIPC_D1_BROWNOUT 3
`define FIPC_D1_CLK_ERR_B 2
`define FIPC_D1_SAR_DONE 1

// second sticky detection layout
`define FIPC_D2_WORD_HALT 7
`define FIPC_D2_MOD_HALT 6

// event status layout
`define FIPC_EVT_START 0
`define FIPC_EVT_END 1
`define FIPC_EVT_SOURCE 2

// timing
`define FIPC_CLK_PERIOD_NS 20
`define FIPC_PULSE_NS 2000000
`define FIPC_PERIOD_NS 4000000
`define FIPC_CNT_W 18

`endif

// ---- verilog/fipc_pkg.sv ----
`include "fipc_consts.svh"

package fipc_pkg;

  typedef enum logic [1:0] {
    FIPC_IDLE,
    FIPC_PULSE_HI,
    FIPC_PULSE_LO,
    FIPC_HOLD
  } fipc_ind_e;

  typedef struct packed {
    logic [7:0] pin_cfg;
    logic [7:0] ind_cfg;
    logic [7:0] mask;
    logic [2:0] evt_status;
    logic [2:0] evt_enable;
    fipc_ind_e ind;
    logic [7:0] rdata;
    logic pin_out;
    logic pin_oe;
    logic pin_pull_up;
    logic pin_pull_down;
    logic pin_buf_en;
    logic irq_out;
    logic [`FIPC_CNT_W-1:0] hi_cnt;
  } fipc_state_s;

endpackage : fipc_pkg

// ---- verilog/fipc_sticky_reg.sv ----
`timescale 1ns/100ps

module fipc_sticky_reg #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // flag control
  input wire logic [W-1:0] set,
  input wire logic clear,
  // flags
  output logic [W-1:0] flags
);
  import fipc_pkg::*;

  typedef struct packed {
    logic [W-1:0] flags;
  } fipc_sticky_s;

  fipc_sticky_s st;
  fipc_sticky_s next_st;

  // a source firing in the clearing read is kept for the next read
  always_comb begin
    next_st = st;
    if (clear) begin
      next_st.flags = '0;
    end
    next_st.flags = next_st.flags | set; // RQ12
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flags = st.flags;

  a_set_wins: assert property (@(posedge clock) disable iff (!rst_n) // RQ12
    (set != '0) |=> ((flags & $past(set)) == $past(set)))
    else $error("sticky flag lost on set");

endmodule : fipc_sticky_reg

// ---- verilog/fipc_pulse_timer.sv ----
`timescale 1ns/100ps

module fipc_pulse_timer #(
  parameter int CW = 18
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic [CW-1:0] length,
  // status
  output logic busy,
  output logic done
);
  import fipc_pkg::*;

  typedef struct packed {
    logic busy;
    logic [CW-1:0] cnt;
  } fipc_timer_s;

  fipc_timer_s st;
  fipc_timer_s next_st;

  // done marks the last cycle of an interval of length cycles
  always_comb begin
    next_st = st;
    if (start) begin
      next_st.busy = 1'b1;
      next_st.cnt = length - CW'(1);
    end else if (st.busy) begin
      next_st.busy = (st.cnt != '0);
      next_st.cnt = st.cnt - CW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy = st.busy;
  assign done = st.busy && (st.cnt == '0);

endmodule : fipc_pulse_timer

// ---- verilog/fipc_irq_ctrl.sv ----
// Notes on behaviour
// (RQ1) drive field bits 7:5 picks push-pull, open-drain low/high, with pull variants
// (RQ2) drive field resets to open drain low-driven, high floating
// (RQ3) function field bits 2:0: off, interrupt, general output, divided clock
// (RQ4) in general output function, bit 4 sets the pin level; resets low
// (RQ5) style 0 gives one active-high 2 ms pulse per interrupt
// (RQ6) style 1 repeats 2 ms pulses every 4 ms while flags remain
// (RQ7) style 2 holds the pin high until all flags clear
// (RQ8) host ends the indication by reading both sticky detection registers
// (RQ9) source mask has one enable bit per fault or clock-halt source
// (RQ10) a mask bit of 1 lets its source interrupt; 0 ignores it
// (RQ11) mask bits and style field reset to zero
// (RQ12) first sticky register latches faults until read; the read clears it
// (RQ13) second sticky register latches word clock halt bit 7, modulator halt bit 6
// (RQ14) an enabled source setting its flag in interrupt function starts an indication
`timescale 1ns/100ps
`include "fipc_consts.svh"

module fipc_irq_ctrl #(
  parameter int PULSE_CYCLES = `FIPC_PULSE_NS / `FIPC_CLK_PERIOD_NS,
  parameter int GAP_CYCLES = (`FIPC_PERIOD_NS - `FIPC_PULSE_NS) / `FIPC_CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // fault, clock-halt and SAR-done events, one-cycle pulses
  input wire logic src_overcurrent,
  input wire logic src_analog_uv,
  input wire logic src_clock_error_a,
  input wire logic src_overtemperature,
  input wire logic src_brownout,
  input wire logic src_clock_error_b,
  input wire logic src_sar_done,
  input wire logic src_word_clock_halt,
  input wire logic src_modulator_halt,
  // divided modulation-input clock
  input wire logic clk_div_in,
  // interrupt pin
  output logic pin_out,
  output logic pin_oe,
  output logic pin_pull_up,
  output logic pin_pull_down,
  output logic pin_buffer_enable,
  // system interrupt
  output logic irq_out
);
  import fipc_pkg::*;

  localparam int CW = `FIPC_CNT_W;

  fipc_state_s st;
  fipc_state_s next_st;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic [7:0] detect_first;
  logic [7:0] detect_second;
  logic [7:0] set_first;
  logic [7:0] set_second;
  logic [7:0] set_masked;
  logic [7:0] flags_masked;
  logic clear_first;
  logic clear_second;
  logic pending;
  logic trigger;
  logic irq_level;
  logic tmr_start;
  logic [CW-1:0] tmr_len;
  logic tmr_done;
  logic [2:0] drive_f;
  logic [2:0] mode_f;
  logic [1:0] style_f;
  logic gpo_f;

  assign drive_f = st.pin_cfg[`FIPC_DRIVE_HI:`FIPC_DRIVE_LO];
  assign mode_f = st.pin_cfg[`FIPC_MODE_HI:`FIPC_MODE_LO];
  assign style_f = st.ind_cfg[`FIPC_STYLE_HI:`FIPC_STYLE_LO];
  assign gpo_f = st.pin_cfg[`FIPC_GPO_BIT];

  // sticky detection layouts
  always_comb begin
    set_first = 8'h00;
    set_first[`FIPC_D1_OVERCURRENT] = src_overcurrent;
    set_first[`FIPC_D1_ANALOG_UV] = src_analog_uv;
    set_first[`FIPC_D1_CLK_ERR_A] = src_clock_error_a;
    set_first[`FIPC_D1_OVERTEMP] = src_overtemperature;
    set_first[`FIPC_D1_BROWNOUT] = src_brownout;
    set_first[`FIPC_D1_CLK_ERR_B] = src_clock_error_b;
    set_first[`FIPC_D1_SAR_DONE] = src_sar_done;
    set_second = 8'h00;
    set_second[`FIPC_D2_WORD_HALT] = src_word_clock_halt; // RQ13
    set_second[`FIPC_D2_MOD_HALT] = src_modulator_halt; // RQ13
  end

  assign clear_first = reg_read && (reg_addr == `FIPC_ADDR_DETECT_FIRST); // RQ12
  assign clear_second = reg_read && (reg_addr == `FIPC_ADDR_DETECT_SECOND); // RQ13

  fipc_sticky_reg #(
    .W(8)
  ) u_detect_first (
    .clock(clock),
    .rst_n(rst_n),
    .set(set_first),
    .clear(clear_first),
    .flags(detect_first)
  );

  fipc_sticky_reg #(
    .W(8)
  ) u_detect_second (
    .clock(clock),
    .rst_n(rst_n),
    .set(set_second),
    .clear(clear_second),
    .flags(detect_second)
  );

  // source events and flags gathered in mask layout, then gated by the mask
  always_comb begin
    set_masked = 8'h00;
    set_masked[`FIPC_M_OVERCURRENT] = src_overcurrent;
    set_masked[`FIPC_M_ANALOG_UV] = src_analog_uv;
    set_masked[`FIPC_M_CLK_ERR_B] = src_clock_error_b;
    set_masked[`FIPC_M_OVERTEMP] = src_overtemperature;
    set_masked[`FIPC_M_BROWNOUT] = src_brownout;
    set_masked[`FIPC_M_CLK_ERR_A] = src_clock_error_a;
    set_masked[`FIPC_M_MOD_HALT] = src_modulator_halt;
    set_masked[`FIPC_M_WORD_HALT] = src_word_clock_halt;
    set_masked = set_masked & st.mask; // RQ9 RQ10
    flags_masked = 8'h00;
    flags_masked[`FIPC_M_OVERCURRENT] = detect_first[`FIPC_D1_OVERCURRENT];
    flags_masked[`FIPC_M_ANALOG_UV] = detect_first[`FIPC_D1_ANALOG_UV];
    flags_masked[`FIPC_M_CLK_ERR_B] = detect_first[`FIPC_D1_CLK_ERR_B];
    flags_masked[`FIPC_M_OVERTEMP] = detect_first[`FIPC_D1_OVERTEMP];
    flags_masked[`FIPC_M_BROWNOUT] = detect_first[`FIPC_D1_BROWNOUT];
    flags_masked[`FIPC_M_CLK_ERR_A] = detect_first[`FIPC_D1_CLK_ERR_A];
    flags_masked[`FIPC_M_MOD_HALT] = detect_second[`FIPC_D2_MOD_HALT];
    flags_masked[`FIPC_M_WORD_HALT] = detect_second[`FIPC_D2_WORD_HALT];
    flags_masked = flags_masked & st.mask; // RQ10
  end

  // reading the detection registers that hold the masked flags, or clearing their mask bits, drops the pending state
  assign pending = (flags_masked != 8'h00); // RQ8
  assign trigger = (mode_f == `FIPC_MODE_INT) && (set_masked != 8'h00); // RQ14
  assign irq_level = (st.ind == FIPC_PULSE_HI) || (st.ind == FIPC_HOLD);

  fipc_pulse_timer #(
    .CW(CW)
  ) u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .start(tmr_start),
    .length(tmr_len),
    .busy(),
    .done(tmr_done)
  );

  always_comb begin
    logic lvl;
    logic en;
    lvl = 1'b0;
    en = 1'b1;
    next_st = st;
    tmr_start = 1'b0;
    tmr_len = CW'(PULSE_CYCLES);

    // register writes; reserved bits of the pin and indication configuration are kept as written, event registers keep only bits 2:0
    if (reg_write) begin
      case (reg_addr)
        `FIPC_ADDR_PIN_CFG: next_st.pin_cfg = reg_wdata; // RQ1 RQ3 RQ4
        `FIPC_ADDR_IND_CFG: next_st.ind_cfg = reg_wdata;
        `FIPC_ADDR_MASK: next_st.mask = reg_wdata; // RQ9
        `FIPC_ADDR_EVT_CLEAR: next_st.evt_status = st.evt_status & ~reg_wdata[2:0];
        `FIPC_ADDR_EVT_ENABLE: next_st.evt_enable = reg_wdata[2:0];
        default: ;
      endcase
    end

    // read data stand only in the cycle after the strobe
    next_st.rdata = 8'h00;
    if (reg_read) begin
      case (reg_addr)
        `FIPC_ADDR_PIN_CFG: next_st.rdata = st.pin_cfg;
        `FIPC_ADDR_IND_CFG: next_st.rdata = st.ind_cfg;
        `FIPC_ADDR_MASK: next_st.rdata = st.mask;
        `FIPC_ADDR_DETECT_FIRST: next_st.rdata = detect_first; // RQ12
        `FIPC_ADDR_DETECT_SECOND: next_st.rdata = detect_second; // RQ13
        `FIPC_ADDR_EVT_STATUS: next_st.rdata = {5'h00, st.evt_status};
        `FIPC_ADDR_EVT_ENABLE: next_st.rdata = {5'h00, st.evt_enable};
        default: next_st.rdata = 8'h00;
      endcase
    end

    // indication sequencer
    case (st.ind)
      FIPC_IDLE: begin
        if (trigger) begin
          case (style_f)
            `FIPC_STYLE_SINGLE, `FIPC_STYLE_REPEAT: begin
              next_st.ind = FIPC_PULSE_HI; // RQ5 RQ6
              tmr_start = 1'b1;
              next_st.evt_status[`FIPC_EVT_START] = 1'b1;
            end
            `FIPC_STYLE_HOLD: begin
              next_st.ind = FIPC_HOLD; // RQ7
              next_st.evt_status[`FIPC_EVT_START] = 1'b1;
            end
            default: ;
          endcase
        end
      end
      FIPC_PULSE_HI: begin
        if (tmr_done) begin
          if (style_f == `FIPC_STYLE_REPEAT) begin
            next_st.ind = FIPC_PULSE_LO; // RQ6
            tmr_start = 1'b1;
            tmr_len = CW'(GAP_CYCLES);
          end else begin
            next_st.ind = FIPC_IDLE; // RQ5
            next_st.evt_status[`FIPC_EVT_END] = 1'b1;
          end
        end
      end
      FIPC_PULSE_LO: begin
        if (tmr_done) begin
          if (pending && style_f == `FIPC_STYLE_REPEAT) begin
            next_st.ind = FIPC_PULSE_HI; // RQ6
            tmr_start = 1'b1;
          end else begin
            next_st.ind = FIPC_IDLE;
            next_st.evt_status[`FIPC_EVT_END] = 1'b1;
          end
        end
      end
      FIPC_HOLD: begin
        if (!pending) begin
          next_st.ind = FIPC_IDLE; // RQ7 RQ8
          next_st.evt_status[`FIPC_EVT_END] = 1'b1;
        end
      end
      default: next_st.ind = FIPC_IDLE;
    endcase
    // leaving the interrupt function abandons any indication in flight
    if (mode_f != `FIPC_MODE_INT) begin
      next_st.ind = FIPC_IDLE;
    end
    if (set_masked != 8'h00) begin
      next_st.evt_status[`FIPC_EVT_SOURCE] = 1'b1;
    end

    // pin function
    case (mode_f)
      `FIPC_MODE_INT: lvl = irq_level; // RQ3
      `FIPC_MODE_GPO: lvl = gpo_f; // RQ4
      `FIPC_MODE_CLK: lvl = clk_div_in; // RQ3
      default: en = 1'b0; // RQ3
    endcase

    // drive style; reserved codes leave the pin floating
    next_st.pin_out = 1'b0;
    next_st.pin_oe = 1'b0;
    next_st.pin_pull_up = 1'b0;
    next_st.pin_pull_down = 1'b0;
    case (drive_f)
      `FIPC_DRV_PUSH_PULL: begin
        next_st.pin_out = lvl; // RQ1
        next_st.pin_oe = 1'b1;
      end
      `FIPC_DRV_OD_LOW, `FIPC_DRV_OD_LOW_PU: begin
        next_st.pin_oe = !lvl; // RQ1 RQ2
        next_st.pin_pull_up = (drive_f == `FIPC_DRV_OD_LOW_PU);
      end
      `FIPC_DRV_OD_HIGH, `FIPC_DRV_OD_HIGH_PD: begin
        next_st.pin_out = 1'b1; // RQ1
        next_st.pin_oe = lvl;
        next_st.pin_pull_down = (drive_f == `FIPC_DRV_OD_HIGH_PD);
      end
      default: ;
    endcase
    if (!en) begin
      next_st.pin_oe = 1'b0;
      next_st.pin_pull_up = 1'b0;
      next_st.pin_pull_down = 1'b0;
    end
    next_st.pin_buf_en = en; // RQ3

    next_st.irq_out = ((next_st.evt_status & st.evt_enable) != 3'h0);
    next_st.hi_cnt = irq_level ? st.hi_cnt + CW'(1) : '0;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '0;
      st.pin_cfg <= `FIPC_PIN_CFG_RST; // RQ2 RQ3 RQ4
      st.ind_cfg <= `FIPC_IND_CFG_RST; // RQ11
      st.mask <= `FIPC_MASK_RST; // RQ11
      st.evt_status <= `FIPC_EVT_RST;
      st.evt_enable <= `FIPC_EVT_RST;
      st.ind <= FIPC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign pin_out = st.pin_out;
  assign pin_oe = st.pin_oe;
  assign pin_pull_up = st.pin_pull_up;
  assign pin_pull_down = st.pin_pull_down;
  assign pin_buffer_enable = st.pin_buf_en;
  assign irq_out = st.irq_out;

  a_config_reset: assert property ($rose(rst_n) |-> // RQ2
    (st.pin_cfg == `FIPC_PIN_CFG_RST && st.ind_cfg == 8'h00 && st.mask == 8'h00))
    else $error("configuration reset values wrong");
  a_mask_blocks: assert property ((st.ind == FIPC_IDLE && st.mask == 8'h00) |=> st.ind == FIPC_IDLE) // RQ11
    else $error("indication started with all sources masked");
  a_open_drain_low: assert property ((drive_f == `FIPC_DRV_OD_LOW && mode_f != `FIPC_MODE_OFF) |=> // RQ1
    (!pin_out && !pin_pull_up && !pin_pull_down))
    else $error("open drain low style drove high");
  a_pin_disabled: assert property ((mode_f == `FIPC_MODE_OFF) |=> (!pin_oe && !pin_buffer_enable)) // RQ3
    else $error("disabled pin still driven");
  a_gpo_level: assert property ((mode_f == `FIPC_MODE_GPO && drive_f == `FIPC_DRV_PUSH_PULL) |=> // RQ4
    (pin_oe && pin_out == $past(gpo_f)))
    else $error("general output level wrong");
  a_pulse_width: assert property (($fell(irq_level) && style_f != `FIPC_STYLE_HOLD // RQ5
    && $past(mode_f) == `FIPC_MODE_INT) |-> st.hi_cnt == CW'(PULSE_CYCLES))
    else $error("pulse width wrong");
  a_repeat_pulse: assert property ((st.ind == FIPC_PULSE_LO && tmr_done && pending // RQ6
    && style_f == `FIPC_STYLE_REPEAT && mode_f == `FIPC_MODE_INT) |=> irq_level)
    else $error("repeat pulse not restarted");
  a_hold_level: assert property ((st.ind == FIPC_HOLD && pending && mode_f == `FIPC_MODE_INT) |=> irq_level) // RQ7
    else $error("held level dropped with flags pending");
  a_trigger_start: assert property ((trigger && st.ind == FIPC_IDLE && style_f != 2'h3) |=> irq_level) // RQ14
    else $error("enabled source did not start indication");
  a_read_clears: assert property ((clear_first && set_first == 8'h00) |=> detect_first == 8'h00) // RQ12
    else $error("read did not clear first detection register");

endmodule : fipc_irq_ctrl

// ---- tb/fipc_host_model.sv ----
`timescale 1ns/100ps

module fipc_host_model (
  // clock
  input wire logic clock,
  // pin drivers of the block
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic pin_pull_up,
  input wire logic pin_pull_down,
  // level seen at the host interrupt input
  output logic pin_level
);
  // a released line without a pull shows the opposite of the last driven level, so a stale level cannot pass
  logic last_driven = 1'b0;

  always @(posedge clock) begin
    if (pin_oe) begin
      last_driven <= pin_out;
    end
  end

  assign pin_level = pin_oe ? pin_out : (pin_pull_up ? 1'b1 : (pin_pull_down ? 1'b0 : ~last_driven));
endmodule : fipc_host_model

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps

module tb_top;
  localparam int P = 20;
  localparam int G = 20;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic [8:0] src = 9'h000;
  logic clk_div_in = 1'b0;
  logic pin_out, pin_oe, pin_pull_up, pin_pull_down, pin_buffer_enable, irq_out, pin_level;
  int bad_count = 0;
  int num_checks = 0;
  int m_reg[3] = '{33, 0, 0};
  logic [7:0] m_d1 = 8'h00;
  logic [7:0] m_d2 = 8'h00;
  logic [31:0] seed = 32'd94096;
  logic [7:0] d;
  int n;

  always #10 clock = ~clock;

  fipc_irq_ctrl #(.PULSE_CYCLES(P), .GAP_CYCLES(G)) DUT (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .src_overcurrent(src[0]), .src_analog_uv(src[1]), .src_clock_error_a(src[2]),
    .src_overtemperature(src[3]), .src_brownout(src[4]), .src_clock_error_b(src[5]),
    .src_sar_done(src[6]), .src_word_clock_halt(src[7]), .src_modulator_halt(src[8]),
    .clk_div_in(clk_div_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pin_pull_up),
    .pin_pull_down(pin_pull_down), .pin_buffer_enable(pin_buffer_enable), .irq_out(irq_out)
  );

  fipc_host_model host (
    .clock(clock), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pin_pull_up),
    .pin_pull_down(pin_pull_down), .pin_level(pin_level)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [3:0] drv_exp(input int c, input logic l);
    case (c)
      0: return {l, 1'b1, 2'b00};
      1: return {1'b0, ~l, 2'b00};
      2: return {1'b1, l, 2'b00};
      3: return {1'b0, ~l, 2'b10};
      default: return {1'b1, l, 2'b01};
    endcase
  endfunction : drv_exp

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic tdone(input string name);
    $display("test %s done", name);
  endtask : tdone

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    if (a >= 8'h23 && a <= 8'h25) begin
      m_reg[a - 8'h23] = v;
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  // the model clears a detection register on its read, like the block must
  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] e;
    e = 8'h00;
    if (a >= 8'h23 && a <= 8'h25) begin
      e = m_reg[a - 8'h23][7:0];
    end else if (a == 8'h26) begin
      e = m_d1;
      m_d1 = 8'h00;
    end else if (a == 8'h27) begin
      e = m_d2;
      m_d2 = 8'h00;
    end
    rd(a, d);
    chk(d, e);
  endtask : rd_chk

  task automatic fire(input int i);
    @(posedge clock);
    src[i] <= 1'b1;
    @(posedge clock);
    src[i] <= 1'b0;
    if (i < 7) begin
      m_d1 = m_d1 | (8'h80 >> i);
    end else begin
      m_d2 = m_d2 | ((i == 7) ? 8'h80 : 8'h40);
    end
    #1;
  endtask : fire

  task automatic run_len(input logic v, input int lim, output int cnt);
    cnt = 0;
    while (pin_level === v && cnt < lim) begin
      cnt++;
      @(posedge clock);
      #1;
    end
  endtask : run_len

  task automatic wait_hi();
    int k;
    run_len(1'b0, 10, k);
    chk({7'h00, pin_level}, 8'h01);
    if (k >= 10) begin
      complete_run();
    end
  endtask : wait_hi

  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask : settle

  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk({5'h00, pin_out, pin_oe, pin_buffer_enable}, 8'h03);
    for (int a = 8'h23; a <= 8'h27; a++) rd_chk(a[7:0]);
    rd_chk(8'h30);
    tdone("reset");
    for (int k = 0; k < 12; k++) begin
      seed = lfsr(seed);
      n = int'(seed[15:8]) % 3;
      wr(8'h23 + n[7:0], seed[7:0]);
    end
    wr(8'h30, 8'hFF);
    wr(8'h26, 8'hFF);
    for (int a = 8'h23; a <= 8'h26; a++) rd_chk(a[7:0]);
    rd_chk(8'h30);
    tdone("registers");
    for (int c = 0; c < 5; c++) begin
      for (int l = 0; l < 2; l++) begin
        wr(8'h23, {c[2:0], l[0], 4'h3});
        settle();
        chk({4'h0, pin_out, pin_oe, pin_pull_up, pin_pull_down}, {4'h0, drv_exp(c, l[0])});
      end
    end
    wr(8'h23, 8'hA3);
    settle();
    chk({7'h00, pin_oe}, 8'h00);
    wr(8'h23, 8'h00);
    settle();
    chk({7'h00, pin_buffer_enable}, 8'h00);
    wr(8'h23, 8'h04);
    for (int v = 1; v >= 0; v--) begin
      @(posedge clock);
      clk_div_in <= v[0];
      settle();
      chk({7'h00, pin_out}, {7'h00, v[0]});
    end
    tdone("pin");
    wr(8'h23, 8'h01);
    wr(8'h24, 8'h00);
    wr(8'h25, 8'h00);
    wr(8'h42, 8'h07);
    for (int i = 0; i < 9; i++) begin
      fire(i);
      run_len(1'b0, 8, n);
      chk(n[7:0], 8'd8);
      rd_chk(8'h26);
      rd_chk(8'h27);
    end
    rd_chk(8'h26);
    chk({7'h00, irq_out}, 8'h00);
    tdone("sticky");
    wr(8'h25, 8'h80);
    fire(0);
    wait_hi();
    run_len(1'b1, 2 * P, n);
    chk(n[7:0], P[7:0]);
    run_len(1'b0, 3 * P, n);
    chk(n[7:0], 8'(3 * P));
    chk({7'h00, irq_out}, 8'h01);
    rd(8'h40, d);
    chk(d, 8'h07);
    wr(8'h42, 8'h00);
    settle();
    chk({7'h00, irq_out}, 8'h00);
    wr(8'h42, 8'h07);
    settle();
    chk({7'h00, irq_out}, 8'h01);
    wr(8'h41, 8'h07);
    rd(8'h40, d);
    chk(d, 8'h00);
    chk({7'h00, irq_out}, 8'h00);
    rd_chk(8'h26);
    rd_chk(8'h27);
    tdone("single");
    wr(8'h24, 8'h40);
    wr(8'h25, 8'h01);
    fire(7);
    wait_hi();
    run_len(1'b1, 2 * P, n);
    chk(n[7:0], P[7:0]);
    run_len(1'b0, 2 * G, n);
    chk(n[7:0], G[7:0]);
    run_len(1'b1, 2 * P, n);
    chk(n[7:0], P[7:0]);
    rd_chk(8'h26);
    rd_chk(8'h27);
    run_len(1'b1, 2 * P, n);
    run_len(1'b0, 3 * P, n);
    chk(n[7:0], 8'(3 * P));
    tdone("repeat");
    wr(8'h24, 8'h80);
    wr(8'h25, 8'h08);
    fire(4);
    wait_hi();
    run_len(1'b1, 3 * P, n);
    chk(n[7:0], 8'(3 * P));
    // only one register read: the flag still stands, so must the level
    rd_chk(8'h27);
    settle();
    chk({7'h00, pin_level}, 8'h01);
    rd_chk(8'h26);
    repeat (4) @(posedge clock);
    #1;
    chk({7'h00, pin_level}, 8'h00);
    tdone("hold");
    complete_run();
  end
endmodule : tb_top
